// file: csf_defs.svh
// Offsets, field positions, reset values and counts of the socket state and force block
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

// Register offsets (byte addresses)
`define CSF_OFS_EVENT      8'h00
`define CSF_OFS_PRESENT    8'h08
`define CSF_OFS_FORCE      8'h0C

// Present-state constant fields
`define CSF_PS_SOCK_CAPS   4'h3
`define CSF_PS_RSVD        14'h0000
`define CSF_PS_RST         32'h3000_0000

// Force event bit positions
`define CSF_FE_RETEST      14
`define CSF_FE_YY          13
`define CSF_FE_XX          12
`define CSF_FE_V3          11
`define CSF_FE_V5          10
`define CSF_FE_BAD         9
`define CSF_FE_LOST        8
`define CSF_FE_NAC         7
`define CSF_FE_CB          5
`define CSF_FE_SIXTEEN     4

// Socket event bit positions and reset value
`define CSF_EV_POWER       3
`define CSF_EV_DET_TWO     2
`define CSF_EV_DET_ONE     1
`define CSF_EV_STATUS      0
`define CSF_EV_RST         4'h0

// Cycles after reset before pin edges may raise events
`define CSF_ARM_CYCLES     2'h3

`endif

// file: csf_pkg.sv
// Types shared by the socket state and force block
package csf_pkg;

  // One register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } csf_bus_req_t;

  // Raw socket pin levels from the card side
  typedef struct packed {
    logic ready_irq;
    logic detect_two;
    logic detect_one;
    logic status;
  } csf_pins_t;

  // Result of one card interrogation
  typedef struct packed {
    logic yy;
    logic xx;
    logic v3;
    logic v5;
    logic cardbus;
    logic sixteen;
    logic unrecognized;
  } csf_card_result_t;

endpackage

// file: csf_socket_state.sv
// Socket present-state, socket event and force event registers of one card socket
`timescale 1ns/100ps
`include "csf_defs.svh"

module csf_socket_state
  import csf_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire csf_pkg::csf_bus_req_t     bus_req,
  output logic [31:0]                    rd_data_q,
  input  wire csf_pkg::csf_pins_t        card_pins,
  input  wire logic                      interrog_busy,
  input  wire logic                      interrog_done,
  input  wire csf_pkg::csf_card_result_t card_result,
  input  wire logic                      socket_powered,
  input  wire logic                      invalid_supply_request,
  input  wire logic                      removal_loss,
  output logic                           retest_req_q,
  output logic                           power_ctrl_en_q
);
  import csf_pkg::*;

  // Address match, used by every register decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Two-stage synchronisers for the four card pins
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  assign pin_raw = card_pins;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // Only the second stage is read by logic
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Synchronised levels, named by use
  wire lvl_ready  = sync2_q[3];
  wire lvl_det2   = sync2_q[2];
  wire lvl_det1   = sync2_q[1];
  wire lvl_status = sync2_q[0];

  // Bus decode
  wire wr_event   = bus_req.wr && addr_hit(bus_req.addr, `CSF_OFS_EVENT);
  wire wr_force   = bus_req.wr && addr_hit(bus_req.addr, `CSF_OFS_FORCE);
  wire rd_event   = addr_hit(bus_req.addr, `CSF_OFS_EVENT);
  wire rd_present = addr_hit(bus_req.addr, `CSF_OFS_PRESENT);
  wire [31:0] wd  = bus_req.wdata;

  // State registers
  logic [1:0] arm_cnt_q;
  logic       armed;
  logic [1:0] det_q;
  logic       stat_prev_q;
  logic       pwr_q;
  logic [3:0] ev_q;
  logic [3:0] ev_d;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic [5:0] card_q;
  logic [5:0] card_d;
  logic       bad_q;
  logic       lost_q;
  logic       nac_q;
  logic       bad_d;
  logic       lost_d;
  logic       nac_d;
  logic [31:0] ps_word;
  logic [31:0] rd_mux;

  // Pin history at reset is unknown, so edges wait until synchronisers settle
  assign armed = (arm_cnt_q == `CSF_ARM_CYCLES);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_cnt_q <= 2'h0;
    end else if (!armed) begin
      arm_cnt_q <= arm_cnt_q + 2'h1;
    end
  end

  // Detect levels freeze while the interrogation drives the pins
  wire [1:0] det_live  = {lvl_det2, lvl_det1};
  wire       det_track = !interrog_busy;
  wire [1:0] det_chg   = (det_track && armed) ? (det_live ^ det_q) : 2'b00;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      det_q <= 2'b11;
    end else if (det_track) begin
      det_q <= det_live;
    end
  end

  // Status edges: rising only for CardBus, both for anything else
  wire stat_rise = lvl_status && !stat_prev_q;
  wire stat_any  = lvl_status ^ stat_prev_q;
  wire stat_evt  = armed && (card_q[1] ? stat_rise : stat_any);
  wire pwr_evt   = armed && (socket_powered != pwr_q);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_prev_q <= 1'b0;
      pwr_q       <= 1'b0;
    end else begin
      stat_prev_q <= lvl_status;
      pwr_q       <= socket_powered;
    end
  end

  // Event register: hardware or force sets, write-one clears, set wins
  assign ev_set = {pwr_evt, det_chg[1], det_chg[0], stat_evt}
                | (wr_force ? wd[3:0] : 4'h0);
  assign ev_clr = wr_event ? wd[3:0] : 4'h0;
  assign ev_d   = (ev_q & ~ev_clr) | ev_set;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_q <= `CSF_EV_RST;
    end else begin
      ev_q <= ev_d;
    end
  end

  // Card fields: loaded by interrogation, overwritten by force writes
  wire [5:0] card_new = {card_result.yy, card_result.xx, card_result.v3,
                         card_result.v5, card_result.cardbus, card_result.sixteen};
  wire [5:0] card_frc = {wd[`CSF_FE_YY], wd[`CSF_FE_XX], wd[`CSF_FE_V3],
                         wd[`CSF_FE_V5], wd[`CSF_FE_CB], wd[`CSF_FE_SIXTEEN]};
  assign card_d = wr_force ? card_frc : (interrog_done ? card_new : card_q);

  // Unrecognized flag leaves the set state only on a valid card or a force write of zero
  assign nac_d  = wr_force ? wd[`CSF_FE_NAC]
                : (interrog_done ? card_result.unrecognized : nac_q);
  // Hardware flags win over a force write of zero in the same cycle
  assign bad_d  = invalid_supply_request || (wr_force ? wd[`CSF_FE_BAD] : bad_q);
  assign lost_d = removal_loss || (wr_force ? wd[`CSF_FE_LOST] : lost_q);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      card_q <= 6'h00;
      bad_q  <= 1'b0;
      lost_q <= 1'b0;
      nac_q  <= 1'b0;
    end else begin
      card_q <= card_d;
      bad_q  <= bad_d;
      lost_q <= lost_d;
      nac_q  <= nac_d;
    end
  end

  // Retest request and socket power control enable
  wire frc_volt = wr_force && (wd[`CSF_FE_YY] || wd[`CSF_FE_XX] ||
                               wd[`CSF_FE_V3] || wd[`CSF_FE_V5]);
  wire frc_test = wr_force && wd[`CSF_FE_RETEST];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      retest_req_q    <= 1'b0;
      power_ctrl_en_q <= 1'b1;
    end else begin
      retest_req_q <= frc_test;
      // Retest wins when both arrive in one write
      if (frc_test) begin
        power_ctrl_en_q <= 1'b1;
      end else if (frc_volt) begin
        power_ctrl_en_q <= 1'b0;
      end
    end
  end

  // Present-state word; socket caps are fixed because no force bit reaches them
  assign ps_word = {`CSF_PS_SOCK_CAPS, `CSF_PS_RSVD, card_q[5:2], bad_q, lost_q, nac_q,
                    lvl_ready, card_q[1:0], pwr_q, det_q, lvl_status};

  // Read mux: force register and unmapped addresses read zero
  assign rd_mux = rd_event   ? {28'h0000000, ev_q} :
                  rd_present ? ps_word : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= bus_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_caps_yy_low:
    assert property (bus_req.rd && rd_present |=> !rd_data_q[31])
      else $error("Y.Y socket capability not zero");
  a_caps_xx_low:
    assert property (bus_req.rd && rd_present |=> !rd_data_q[30])
      else $error("X.X socket capability not zero");
  a_caps_v3_high:
    assert property (bus_req.rd && rd_present |=> rd_data_q[29])
      else $error("3.3 V socket capability not set");
  a_caps_v5_high:
    assert property (bus_req.rd && rd_present |=> rd_data_q[28])
      else $error("5 V socket capability not set");
  a_present_rsvd_zero:
    assert property (bus_req.rd && rd_present |=> rd_data_q[27:14] == 14'h0000)
      else $error("Present-state reserved bits not zero");
  a_card_volt_load:
    assert property (interrog_done && !wr_force |=> card_q[5:2] == $past(card_new[5:2]))
      else $error("Card voltage support not loaded");
  a_bad_req_set:
    assert property (invalid_supply_request |=> bad_q)
      else $error("Invalid supply flag not set");
  a_loss_flag_set:
    assert property (removal_loss |=> lost_q)
      else $error("Removal loss flag not set");
  a_nac_hold:
    assert property (nac_q && !interrog_done && !wr_force |=> nac_q)
      else $error("Unrecognized flag dropped without valid card");
  a_ready_level:
    assert property (bus_req.rd && rd_present |=> rd_data_q[6] == $past(sync2_q[3]))
      else $error("Ready level not shown");
  a_type_stable:
    assert property (!interrog_done && !wr_force |=> $stable(card_q[1:0]))
      else $error("Card type changed without interrogation");
  a_power_follow:
    assert property (socket_powered ##1 socket_powered |-> pwr_q)
      else $error("Powered bit not following");
  a_detect_frozen:
    assert property (interrog_busy |=> $stable(det_q))
      else $error("Detect level moved during interrogation");
  a_status_level:
    assert property (bus_req.rd && rd_present |=> rd_data_q[0] == $past(sync2_q[0]))
      else $error("Status level not shown");
  a_force_reads_zero:
    assert property (bus_req.rd && addr_hit(bus_req.addr, `CSF_OFS_FORCE)
                     |=> rd_data_q == 32'h0000_0000)
      else $error("Force register read not zero");
  a_event_set_wins:
    assert property (pwr_evt && wr_event && wd[3] |=> ev_q[3])
      else $error("Power event lost to clear");
  a_event_clear:
    assert property (wr_event && wd[0] && !ev_set[0] |=> !ev_q[0])
      else $error("Status event not cleared");
  a_cb_fall_quiet:
    assert property (armed && card_q[1] && !lvl_status && stat_prev_q && !wr_force
                     && !ev_q[0] |=> !ev_q[0])
      else $error("CardBus falling edge raised status event");
  a_force_event:
    assert property (wr_force && wd[2] && (interrog_busy || det_live == det_q)
                     |=> ev_q[2] && $stable(det_q))
      else $error("Forced detect event missing or detect level moved");
  a_retest_pulse:
    assert property (frc_test |=> retest_req_q && power_ctrl_en_q
                     ##1 (!retest_req_q || $past(frc_test)))
      else $error("Retest request not one pulse");
  a_sync_delay:
    assert property (armed && $stable(pin_raw) [*3] |-> sync2_q == pin_raw)
      else $error("Synchroniser not two stages");

  // Read data path
  a_idle_read_zero:
    assert property (!bus_req.rd |=> rd_data_q == 32'h0000_0000)
      else $error("Read data not zero outside a read");
  a_unmapped_zero:
    assert property (bus_req.rd && !rd_event && !rd_present |=> rd_data_q == 32'h0000_0000)
      else $error("Unmapped or force read not zero");
  a_event_word:
    assert property (bus_req.rd && rd_event |=> rd_data_q == {28'h0000000, $past(ev_q)})
      else $error("Event register read wrong");
  a_read_detect:
    assert property (bus_req.rd && rd_present |=> rd_data_q[2:1] == $past(det_q))
      else $error("Detect levels not shown");
  a_read_power:
    assert property (bus_req.rd && rd_present |=> rd_data_q[3] == $past(pwr_q))
      else $error("Powered bit not shown");

  // Event setting by hardware and by force
  a_power_event_set:
    assert property (pwr_evt |=> ev_q[`CSF_EV_POWER])
      else $error("Power change did not raise its event");
  a_det_two_event:
    assert property (det_chg[1] |=> ev_q[`CSF_EV_DET_TWO])
      else $error("Detect two change did not raise its event");
  a_det_one_event:
    assert property (det_chg[0] |=> ev_q[`CSF_EV_DET_ONE])
      else $error("Detect one change did not raise its event");
  a_status_rise_cb:
    assert property (armed && card_q[1] && stat_rise |=> ev_q[`CSF_EV_STATUS])
      else $error("CardBus rising status edge lost");
  a_status_both_edges:
    assert property (armed && !card_q[1] && stat_any |=> ev_q[`CSF_EV_STATUS])
      else $error("Status edge lost for a 16-bit card");
  a_force_power_event:
    assert property (wr_force && wd[3] |=> ev_q[`CSF_EV_POWER])
      else $error("Forced power event missing");
  a_force_pwr_level:
    assert property (wr_force && wd[3] |=> pwr_q == $past(socket_powered))
      else $error("Forced power event moved the powered bit");

  // Force writes copy into the present-state fields
  // A force write of zero clears a field too; only bits 9 and 8 let hardware win
  a_force_card_copy:
    assert property (wr_force |=> card_q == $past(card_frc))
      else $error("Forced card fields not copied");
  a_force_nac_copy:
    assert property (wr_force |=> nac_q == $past(wd[`CSF_FE_NAC]))
      else $error("Forced unrecognized flag not copied");
  a_force_bad_copy:
    assert property (wr_force && !invalid_supply_request |=> bad_q == $past(wd[`CSF_FE_BAD]))
      else $error("Forced invalid supply flag not copied");
  a_force_lost_copy:
    assert property (wr_force && !removal_loss |=> lost_q == $past(wd[`CSF_FE_LOST]))
      else $error("Forced removal loss flag not copied");

  // Flags and fields that must hold between their events
  a_bad_hold:
    assert property (bad_q && !wr_force |=> bad_q)
      else $error("Invalid supply flag dropped by itself");
  a_lost_hold:
    assert property (lost_q && !wr_force |=> lost_q)
      else $error("Removal loss flag dropped by itself");
  a_volt_stable:
    assert property (!interrog_done && !wr_force |=> $stable(card_q[5:2]))
      else $error("Card voltage support changed without interrogation");
  a_nac_load:
    assert property (interrog_done && !wr_force |=> nac_q == $past(card_result.unrecognized))
      else $error("Unrecognized flag not loaded by interrogation");
  a_detect_track:
    assert property (!interrog_busy |=> det_q == $past(det_live))
      else $error("Detect levels not tracking outside interrogation");

  // Socket power control and retest request
  a_volt_disables:
    assert property (frc_volt && !frc_test |=> !power_ctrl_en_q)
      else $error("Forced card voltage did not disable power control");
  a_retest_quiet:
    assert property (!frc_test |=> !retest_req_q)
      else $error("Retest request without a write");
  a_power_ctrl_hold:
    assert property (!frc_test && !frc_volt |=> $stable(power_ctrl_en_q))
      else $error("Power control enable moved without a force write");

  c_force_retest:  cover property (frc_test ##1 interrog_busy [*2] ##1 interrog_done);
  c_status_event:  cover property (stat_evt ##[1:20] wr_event && wd[0]);
  c_unrecognized:  cover property (nac_q ##[1:50] interrog_done && !card_result.unrecognized);
  c_volt_force:    cover property (frc_volt ##1 !power_ctrl_en_q);
  c_flag_wins:     cover property (invalid_supply_request && wr_force && !wd[`CSF_FE_BAD]);

endmodule

// file: csf_card_model.sv
// Card model for one socket: pin levels and interrogation answers
`timescale 1ns/100ps
module csf_card_model
  import csf_pkg::*;
(
  input  wire logic                core_clk,
  output csf_pkg::csf_pins_t       card_pins,
  output logic                     interrog_busy,
  output logic                     interrog_done,
  output csf_pkg::csf_card_result_t card_result
);
  import csf_pkg::*;

  // Empty socket at power-up: detect pins float high, ready pin high
  initial begin
    card_pins = 4'hE;
    interrog_busy = 1'b0;
    interrog_done = 1'b0;
    card_result = 7'h00;
  end

  // Pins move just after an edge; the block must still resynchronise them
  task automatic set_pins(input csf_pins_t p);
    @(posedge core_clk);
    card_pins <= p;
  endtask

  // Identify the card; the sense lines bounce meanwhile because they are reused
  task automatic interrogate(input csf_card_result_t res);
    csf_pins_t keep;
    keep = card_pins;
    @(posedge core_clk);
    interrog_busy <= 1'b1;
    card_pins.detect_two <= ~keep.detect_two;
    card_pins.detect_one <= ~keep.detect_one;
    repeat (12) @(posedge core_clk);
    card_pins <= keep;
    repeat (6) @(posedge core_clk);
    interrog_done <= 1'b1;
    card_result <= res;
    @(posedge core_clk);
    interrog_done <= 1'b0;
    interrog_busy <= 1'b0;
    // Result is only valid with done, so show a changed pattern afterwards
    card_result <= ~res;
  endtask
endmodule

// file: csf_socket_state_tb.sv
// Self-checking bench of the socket state and force block
`timescale 1ns/100ps
module csf_socket_state_tb;
  import csf_pkg::*;
  logic             core_clk;
  logic             arst_n;
  csf_bus_req_t     bus_req;
  logic [31:0]      rd_data_q;
  csf_pins_t        card_pins;
  logic             interrog_busy;
  logic             interrog_done;
  csf_card_result_t card_result;
  logic             socket_powered;
  logic             invalid_supply_request;
  logic             removal_loss;
  logic             retest_req_q;
  logic             power_ctrl_en_q;
  int               bad_count;
  int               check_count;

  csf_socket_state uut (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req),
    .rd_data_q(rd_data_q), .card_pins(card_pins), .interrog_busy(interrog_busy),
    .interrog_done(interrog_done), .card_result(card_result),
    .socket_powered(socket_powered), .invalid_supply_request(invalid_supply_request),
    .removal_loss(removal_loss), .retest_req_q(retest_req_q),
    .power_ctrl_en_q(power_ctrl_en_q));

  csf_card_model card (.core_clk(core_clk), .card_pins(card_pins),
    .interrog_busy(interrog_busy), .interrog_done(interrog_done),
    .card_result(card_result));

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // One compare for every kind of result; narrow values are zero extended
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Single-cycle write; returns just after the edge that took it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  // Single-cycle read; data is looked at in the one cycle where it stands
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(n, e, rd_data_q);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #(25 * 4000);
    bad_count++;
    close_out();
  end

  // Test sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    bus_req = '0;
    socket_powered = 1'b0;
    invalid_supply_request = 1'b0;
    removal_loss = 1'b0;
    cyc(20);
    arst_n <= 1'b1;
    cyc(5);
    rd_chk("present_reset", 8'h08, 32'h3000_0046);
    rd_chk("force_read", 8'h0C, 32'h0000_0000);
    rd_chk("event_reset", 8'h00, 32'h0000_0000);
    rd_chk("unmapped", 8'h04, 32'h0000_0000);
    chk("power_ctrl_reset", 32'h1, power_ctrl_en_q);
    $display("test reset done");
    // Insertion pulls both detect pins low outside interrogation
    card.set_pins(4'h8);
    cyc(5);
    rd_chk("present_insert", 8'h08, 32'h3000_0040);
    rd_chk("event_insert", 8'h00, 32'h0000_0006);
    wr(8'h00, 32'h0000_0006);
    rd_chk("event_cleared", 8'h00, 32'h0000_0000);
    $display("test insertion done");
    // Detect bounce during interrogation must stay hidden
    fork
      card.interrogate(7'b0010100);
      begin
        cyc(8);
        rd_chk("present_frozen", 8'h08, 32'h3000_0040);
      end
    join
    rd_chk("present_cardbus", 8'h08, 32'h3000_0860);
    rd_chk("event_frozen", 8'h00, 32'h0000_0000);
    $display("test interrogation done");
    // CardBus card: only the rising status edge is an event
    card.set_pins(4'h9);
    cyc(5);
    rd_chk("present_status", 8'h08, 32'h3000_0861);
    rd_chk("event_rise_cb", 8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    card.set_pins(4'h0);
    cyc(5);
    rd_chk("present_ready_low", 8'h08, 32'h3000_0820);
    rd_chk("event_fall_cb", 8'h00, 32'h0000_0000);
    $display("test cardbus status done");
    // Forced 16-bit card: both status edges are events
    wr(8'h0C, 32'h0000_0010);
    rd_chk("present_forced16", 8'h08, 32'h3000_0010);
    card.set_pins(4'h1);
    cyc(5);
    rd_chk("event_rise_16", 8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    card.set_pins(4'h0);
    cyc(5);
    rd_chk("event_fall_16", 8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    $display("test sixteen bit status done");
    // Force every action bit, then ask for re-interrogation
    wr(8'h0C, 32'h0000_3FFF);
    rd_chk("present_forced", 8'h08, 32'h3000_3FB0);
    rd_chk("event_forced", 8'h00, 32'h0000_000F);
    chk("power_ctrl_off", 32'h0, power_ctrl_en_q);
    wr(8'h0C, 32'h0000_4000);
    chk("retest_pulse", 32'h1, retest_req_q);
    chk("power_ctrl_on", 32'h1, power_ctrl_en_q);
    cyc(1);
    #1;
    chk("retest_end", 32'h0, retest_req_q);
    rd_chk("force_read_back", 8'h0C, 32'h0000_0000);
    rd_chk("present_retest", 8'h08, 32'h3000_0000);
    wr(8'h00, 32'h0000_000F);
    $display("test force done");
    // Hardware flags and socket power
    @(posedge core_clk);
    socket_powered <= 1'b1;
    invalid_supply_request <= 1'b1;
    removal_loss <= 1'b1;
    @(posedge core_clk);
    invalid_supply_request <= 1'b0;
    removal_loss <= 1'b0;
    cyc(3);
    rd_chk("present_flags", 8'h08, 32'h3000_0308);
    rd_chk("event_power", 8'h00, 32'h0000_0008);
    $display("test flags done");
    // Unrecognised card holds bit 7 until a valid card is found
    card.interrogate(7'b0100001);
    rd_chk("present_not_card", 8'h08, 32'h3000_1388);
    card.interrogate(7'b1001010);
    rd_chk("present_valid", 8'h08, 32'h3000_2718);
    $display("test unrecognised done");
    // Power-down event, then a hardware flag beating a force write of zero
    wr(8'h00, 32'h0000_0008);
    @(posedge core_clk);
    socket_powered <= 1'b0;
    cyc(4);
    rd_chk("present_power_off", 8'h08, 32'h3000_2710);
    rd_chk("event_power_off", 8'h00, 32'h0000_0008);
    fork
      wr(8'h0C, 32'h0000_0000);
      begin
        @(posedge core_clk);
        invalid_supply_request <= 1'b1;
        @(posedge core_clk);
        invalid_supply_request <= 1'b0;
      end
    join
    rd_chk("present_flag_wins", 8'h08, 32'h3000_0200);
    $display("test power off done");
    // Reset in mid-run: detect history restarts without a false event
    @(posedge core_clk);
    arst_n <= 1'b0;
    cyc(3);
    arst_n <= 1'b1;
    cyc(5);
    rd_chk("present_rearm", 8'h08, 32'h3000_0000);
    rd_chk("event_rearm", 8'h00, 32'h0000_0000);
    chk("power_ctrl_rearm", 32'h1, power_ctrl_en_q);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
